// >>> rtl/rfs_supervisor.sv
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "rfs_defs.svh"
module rfs_supervisor
   import rfs_pkg::*;
#(
   parameter logic [31:0] AL_PERIOD_CYC = `RFS_AL_PERIOD_CYC
) (
   input  wire logic        aclk,              // 100 MHz clock
   input  wire logic        aresetn,           // sync reset, low
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,      // write address
   input  wire logic        s_axi_awvalid,     // write addr valid
   output logic             s_axi_awready,     // write addr ready
   input  wire logic [31:0] s_axi_wdata,       // write data
   input  wire logic [3:0]  s_axi_wstrb,       // byte strobes
   input  wire logic        s_axi_wvalid,      // write data valid
   output logic             s_axi_wready,      // write data ready
   output logic [1:0]       s_axi_bresp,       // write response
   output logic             s_axi_bvalid,      // response valid
   input  wire logic        s_axi_bready,      // response ready
   input  wire logic [7:0]  s_axi_araddr,      // read address
   input  wire logic        s_axi_arvalid,     // read addr valid
   output logic             s_axi_arready,     // read addr ready
   output logic [31:0]      s_axi_rdata,       // read data
   output logic [1:0]       s_axi_rresp,       // read response
   output logic             s_axi_rvalid,      // read data valid
   input  wire logic        s_axi_rready,      // read data ready
   // fault comparators and pins
   input  wire logic        enable_in,         // enable pin level
   input  wire logic        ov_trip,           // feedback above 1 V
   input  wire logic        ov_release,        // feedback below 0.85 V
   input  wire logic        therm_trip,        // junction at 155 C
   input  wire logic        therm_cool,        // junction at 135 C
   input  wire logic        first_overcurrent, // level-one limit hit
   input  wire logic        second_overcurrent,// level-two limit hit
   input  wire logic        al_pin_zero,       // alarm pin at ground
   input  wire logic        al_pin_high,       // alarm pin above 0.2 V
   // outputs
   input  wire logic        power_good_out_i,  // power-good wire level
   output logic             power_good_out_o,  // open drain, drives 0
   output logic             power_good_out_oe, // high pulls pin low
   output logic             bridge_switch_en,  // bridge may switch
   output logic             bridge_hiz,        // both switches off
   output logic             hs_turn_off,       // end this on-time
   output logic             ss_discharge,      // pull ramp to ground
   output logic             al_cap_discharge,  // reset timing cap
   output logic             al_cap_charge,     // charge timing cap
   output logic             irq                // level interrupt
);

   // ************************************************
   // behaviour overview
   // ************************************************

   // overvoltage and thermal flags gate the bridge
   // directly; the overvoltage flag does not move the sequence.

   // a thermal trip or a level-two overcurrent while
   // switching is an alarm: the bridge stops, the
   // ramp is pulled down and cooling begins.

   // cooling waits for the thermal flag to clear,
   // then runs sixteen timer periods.

   // watching runs three cooling lengths; a quiet
   // window clears the alarm count (hiccup).

   // a count of sixteen inside watching latches the
   // regulator off until enable is cycled.

   // alarm pin levels override the count: grounded
   // never latches, high latches at once.

   // limitation: the period timer runs freely, so
   // it is reloaded at each alarm to give whole
   // periods from the alarm edge.

   // trade-off: outputs are registered, so a fault
   // reaches the pins one cycle after it is seen;
   // the analog loop ends the on-time first.

   // level-one overcurrent raises no alarm; it only
   // asks the driver to end the present on-time.

   // status shows flags, count and the pin level;
   // the period register may be shortened in tests.

   // a zero period is stored as one, since a zero
   // reload would never let the timer expire.

   // interrupt status is write-one-to-clear; an
   // event in the cycle of its clear survives.

   // ************************************************
   // address decode, shared by read and write paths
   // ************************************************
   // returns one-hot select: period, status, irq stat, mask
   function automatic logic [3:0] reg_sel(input logic [7:0] a);
      logic [3:0] s;
      s = 4'h0;
      case (a)
         `RFS_REG_PERIOD:   s = 4'h1;
         `RFS_REG_STATUS:   s = 4'h2;
         `RFS_REG_IRQ_STAT: s = 4'h4;
         `RFS_REG_IRQ_MASK: s = 4'h8;
         default:           s = 4'h0;
      endcase
      return s;
   endfunction

   // byte-lane merge of a write into a 32-bit word
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  be);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            m[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return m;
   endfunction

   // ************************************************
   // state
   // ************************************************
   rfs_st_type q;                  // registered state
   rfs_st_type d;                  // next state

   localparam logic [6:0] COOL_N =
      7'(`RFS_COOL_PERIODS);        // cooling length in periods
   localparam logic [6:0] WATCH_N =
      7'(`RFS_COOL_PERIODS * `RFS_WATCH_MULT);
   localparam logic [4:0] LATCH_N = 5'(`RFS_LATCH_COUNT);

   // ************************************************
   // next-state logic
   // ************************************************
   always_comb begin
      logic        alarm;          // thermal or level-two event
      logic        per_end;        // one timer period elapsed
      logic        wr_go;          // both write halves present
      logic        rd_go;          // read address taken
      logic [3:0]  wsel;           // write register select
      logic [3:0]  rsel;           // read register select
      logic [4:0]  ev;             // interrupt events this cycle
      logic [4:0]  clr;            // interrupt clears this cycle
      logic [31:0] wv;             // merged write value
      alarm   = 1'b0;
      per_end = 1'b0;
      wr_go   = 1'b0;
      rd_go   = 1'b0;
      wsel    = 4'h0;
      rsel    = 4'h0;
      ev      = 5'h00;
      clr     = 5'h00;
      wv      = 32'h0000_0000;
      d       = q;

      // overvoltage flag: set above 1 V, held until release
      if (ov_trip && !q.ov) begin
         d.ov = 1'b1;
         ev[`RFS_IRQ_OV] = 1'b1;
      end else if (q.ov && ov_release && !ov_trip) begin
         d.ov = 1'b0;
      end

      // thermal flag clears only at the lower threshold
      if (therm_trip && !q.therm) begin
         d.therm = 1'b1;
         ev[`RFS_IRQ_THERM] = 1'b1;
      end else if (q.therm && therm_cool && !therm_trip) begin
         d.therm = 1'b0;
      end

      // level-two overcurrent only counts while switching
      if (second_overcurrent && q.sw_en) begin
         ev[`RFS_IRQ_OC2] = 1'b1;
      end
      alarm = (therm_trip && !q.therm) ||
              (second_overcurrent && q.sw_en);

      // period timer; reloads from the software value
      per_end = (q.per_cnt == 32'h0000_0000);
      if (per_end) begin
         d.per_cnt = q.al_period - 32'h0000_0001;
         d.per_idx = q.per_idx + 7'h01;
      end else begin
         d.per_cnt = q.per_cnt - 32'h0000_0001;
      end

      // supervisor sequence
      case (q.state)
         ST_OFF: begin
            d.alarm_cnt = 5'h00;
            if (enable_in) begin
               d.state = ST_RUN;
            end
         end
         ST_RUN, ST_WATCH: begin
            if (alarm) begin
               // counts each alarm; pin forces the outcome
               d.alarm_cnt = q.alarm_cnt + 5'h01;
               if (al_pin_high && !al_pin_zero) begin
                  d.state = ST_LATCH;
               end else if (!al_pin_zero &&
                            q.state == ST_WATCH &&
                            q.alarm_cnt + 5'h01 >= LATCH_N) begin
                  d.state = ST_LATCH;
               end else begin
                  d.state = ST_COOL;
                  if (al_pin_zero) begin
                     d.alarm_cnt = 5'h01;
                  end
               end
               // discharge the timer, then count from zero
               d.per_cnt = q.al_period;
               d.per_idx = 7'h00;
            end else if (q.state == ST_WATCH &&
                         per_end && q.per_idx + 7'h01 >= WATCH_N) begin
               d.state     = ST_RUN;
               d.alarm_cnt = 5'h00;
               ev[`RFS_IRQ_QUIET] = 1'b1;
            end
         end
         ST_COOL: begin
            if (q.therm) begin
               // cooling starts only once the thermal fault clears
               d.per_cnt = q.al_period;
               d.per_idx = 7'h00;
            end else if (per_end &&
                         q.per_idx + 7'h01 >= COOL_N) begin
               d.state   = ST_WATCH;
               d.per_idx = 7'h00;
            end
         end
         ST_LATCH: begin
            // only the enable pin leaves this state
            d.alarm_cnt = q.alarm_cnt;
         end
         default: begin
            d.state = ST_OFF;
         end
      endcase
      if (d.state == ST_LATCH && q.state != ST_LATCH) begin
         ev[`RFS_IRQ_LATCH] = 1'b1;
      end
      // enable low overrides all, and is the only latch exit
      if (!enable_in) begin
         d.state = ST_OFF;
      end

      // ---------------- axi4-lite write ----------------
      if (s_axi_awvalid && s_axi_awready) begin
         d.aw_have = 1'b1;
         d.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         d.w_have = 1'b1;
         d.wdata  = s_axi_wdata;
         d.wstrb  = s_axi_wstrb;
      end
      wr_go = q.aw_have && q.w_have && !q.bvalid;
      if (wr_go) begin
         wsel     = reg_sel(q.awaddr);
         d.aw_have = 1'b0;
         d.w_have  = 1'b0;
         d.bvalid  = 1'b1;
         d.bresp   = (wsel == 4'h0) ? `RFS_RESP_SLVERR
                                    : `RFS_RESP_OKAY;
         if (wsel[0]) begin
            wv = merge(q.al_period, q.wdata, q.wstrb);
            // a zero period would stall the timer; keep one
            d.al_period = (wv == 32'h0000_0000) ? 32'h0000_0001 : wv;
         end
         if (wsel[2] && q.wstrb[0]) begin
            clr = q.wdata[4:0];              // write one to clear
         end
         if (wsel[3] && q.wstrb[0]) begin
            d.irq_mask = q.wdata[4:0];
         end
      end else if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      // new events win over a clear in the same cycle
      d.irq_stat = (q.irq_stat & ~clr) | ev;

      // ---------------- axi4-lite read -----------------
      rd_go = s_axi_arvalid && s_axi_arready;
      if (rd_go) begin
         rsel    = reg_sel(s_axi_araddr);
         d.rvalid = 1'b1;
         d.rresp  = (rsel == 4'h0) ? `RFS_RESP_SLVERR
                                   : `RFS_RESP_OKAY;
         d.rdata  = 32'h0000_0000;
         if (rsel[0]) begin
            d.rdata = q.al_period;
         end
         if (rsel[1]) begin
            d.rdata = {16'h0000, 3'h0, power_good_out_i,
                       q.alarm_cnt, q.therm, q.ov, q.state};
         end
         if (rsel[2]) begin
            d.rdata = {27'h0, q.irq_stat};
         end
         if (rsel[3]) begin
            d.rdata = {27'h0, q.irq_mask};
         end
      end else if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end

      // ---------------- pin outputs --------------------
      // bridge switches only when regulating and fault free
      d.sw_en  = (d.state == ST_RUN || d.state == ST_WATCH) &&
                 !d.ov && !d.therm;
      d.hiz    = !d.sw_en;
      d.pg_oe  = !d.sw_en;
      d.ss_dis = (d.state != ST_RUN &&
                  d.state != ST_WATCH);
      d.al_dis = (d.state == ST_COOL &&
                  q.state != ST_COOL);
      d.al_chg = (d.state == ST_COOL ||
                  d.state == ST_WATCH) && !d.al_dis;
      // level one: cut on-time only, no alarm, pg untouched
      d.hs_stop = first_overcurrent && d.sw_en;
   end

   // ************************************************
   // state register
   // ************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q           <= '0;
         q.state     <= ST_OFF;
         q.al_period <= AL_PERIOD_CYC;
         q.per_cnt   <= AL_PERIOD_CYC;
         q.pg_oe     <= 1'b1;
         q.hiz       <= 1'b1;
         q.ss_dis    <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ************************************************
   // outputs
   // ************************************************
   // one write in flight: halves accepted until both held
   assign s_axi_awready     = !q.aw_have && !q.bvalid;
   assign s_axi_wready      = !q.w_have && !q.bvalid;
   assign s_axi_bvalid      = q.bvalid;
   assign s_axi_bresp       = q.bresp;
   assign s_axi_arready     = !q.rvalid;
   assign s_axi_rvalid      = q.rvalid;
   assign s_axi_rdata       = q.rdata;
   assign s_axi_rresp       = q.rresp;
   assign power_good_out_o  = 1'b0;
   assign power_good_out_oe = q.pg_oe;
   assign bridge_switch_en  = q.sw_en;
   assign bridge_hiz        = q.hiz;
   assign hs_turn_off       = q.hs_stop;
   assign ss_discharge      = q.ss_dis;
   assign al_cap_discharge  = q.al_dis;
   assign al_cap_charge     = q.al_chg;
   assign irq               = |(q.irq_stat & q.irq_mask);

endmodule

// >>> rtl/rfs_defs.svh
`ifndef RFS_DEFS_SVH
`define RFS_DEFS_SVH
// ***************************************************
// timing: alarm period from cap, current and threshold
// ***************************************************
`define RFS_AL_CAP_NF      1000
`define RFS_AL_K_MV        3100
`define RFS_AL_I_NA        20000
`define RFS_CLK_NS         10
// nF * mV / nA gives milliseconds
`define RFS_AL_PERIOD_MS   ((`RFS_AL_CAP_NF*`RFS_AL_K_MV)/`RFS_AL_I_NA)
`define RFS_AL_PERIOD_CYC  ((`RFS_AL_PERIOD_MS*1000000)/`RFS_CLK_NS)
`define RFS_COOL_PERIODS   16
`define RFS_WATCH_MULT     3
`define RFS_LATCH_COUNT    16
// ***************************************************
// register map (byte offsets) and interrupt bits
// ***************************************************
`define RFS_REG_PERIOD     8'h00
`define RFS_REG_STATUS     8'h04
`define RFS_REG_IRQ_STAT   8'h08
`define RFS_REG_IRQ_MASK   8'h0C
`define RFS_IRQ_OV         0
`define RFS_IRQ_THERM      1
`define RFS_IRQ_OC2        2
`define RFS_IRQ_LATCH      3
`define RFS_IRQ_QUIET      4
`define RFS_IRQ_W          5
`define RFS_RESP_OKAY      2'h0
`define RFS_RESP_SLVERR    2'h2
`endif

// >>> rtl/rfs_pkg.sv
package rfs_pkg;
   // ************************************************
   // supervisor states, one-hot
   // ************************************************
   typedef enum logic [4:0] {
      ST_OFF   = 5'h01,   // enable low
      ST_RUN   = 5'h02,   // regulating
      ST_COOL  = 5'h04,   // bridge off, ramp discharged
      ST_WATCH = 5'h08,   // restarted, watching for alarms
      ST_LATCH = 5'h10    // latched off
   } rfs_state_type;

   // ************************************************
   // all state of the supervisor
   // ************************************************
   typedef struct packed {
      rfs_state_type state;
      logic          ov;
      logic          therm;
      logic [4:0]    alarm_cnt;
      logic [31:0]   per_cnt;
      logic [6:0]    per_idx;
      logic [31:0]   al_period;
      logic [4:0]    irq_stat;
      logic [4:0]    irq_mask;
      logic          aw_have;
      logic [7:0]    awaddr;
      logic          w_have;
      logic [31:0]   wdata;
      logic [3:0]    wstrb;
      logic          bvalid;
      logic [1:0]    bresp;
      logic          rvalid;
      logic [31:0]   rdata;
      logic [1:0]    rresp;
      logic          pg_oe;
      logic          sw_en;
      logic          hiz;
      logic          ss_dis;
      logic          al_dis;
      logic          al_chg;
      logic          hs_stop;
   } rfs_st_type;
endpackage

// >>> tb/rfs_supervisor_sva.sv
`timescale 1ns/100ps
module rfs_supervisor_sva (
   input wire logic aclk,               // clock
   input wire logic aresetn,            // sync reset, low
   input wire logic enable_in,          // enable pin
   input wire logic ov_trip,            // overvoltage trip
   input wire logic therm_trip,         // thermal trip
   input wire logic first_overcurrent,  // level one
   input wire logic second_overcurrent, // level two
   input wire logic al_pin_high,        // forced latch
   input wire logic power_good_out_o,   // pg drive value
   input wire logic power_good_out_oe,  // pg pull enable
   input wire logic bridge_switch_en,   // bridge switching
   input wire logic bridge_hiz,         // both switches off
   input wire logic hs_turn_off,        // end on-time
   input wire logic ss_discharge,       // ramp discharge
   input wire logic al_cap_discharge,   // cap reset pulse
   input wire logic al_cap_charge       // cap charging
);
   // ****
   // fault responses, one to eight cycles after the cause, and output invariants
   // ****
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   AST_OV: assert property (
      ov_trip |=> bridge_hiz && power_good_out_oe)
      else $error("bridge not off after overvoltage");
   AST_THERM: assert property (
      therm_trip |=> bridge_hiz && power_good_out_oe)
      else $error("bridge not off after thermal trip");
   AST_HIZ: assert property (
      bridge_hiz == !bridge_switch_en)
      else $error("high impedance and switching disagree");
   AST_PG: assert property (
      !power_good_out_o && (power_good_out_oe || bridge_switch_en))
      else $error("power good released while bridge off");
   AST_OC1: assert property (
      first_overcurrent && bridge_switch_en && enable_in && !ov_trip
      && !therm_trip && !second_overcurrent
      |=> hs_turn_off && bridge_switch_en)
      else $error("first overcurrent mishandled");
   AST_OC2: assert property (
      second_overcurrent && bridge_switch_en && enable_in
      |=> !bridge_switch_en && power_good_out_oe ##1 ss_discharge)
      else $error("second overcurrent did not stop bridge");
   AST_CAP: assert property (
      al_cap_discharge && enable_in |=> al_cap_charge && !al_cap_discharge)
      else $error("timing cap not charged after discharge");
   AST_FORCE: assert property (
      al_pin_high && second_overcurrent && bridge_switch_en && enable_in
      ##1 enable_in [*8] |-> !bridge_switch_en)
      else $error("forced latch let bridge restart");
   AST_OFF: assert property (
      !enable_in |=> bridge_hiz && ss_discharge && !al_cap_charge)
      else $error("enable low did not stop regulator");
   // main scenarios
   cover property (al_cap_discharge);
   cover property (hs_turn_off && bridge_switch_en);
   cover property ($rose(bridge_switch_en) && !ss_discharge);
endmodule

// >>> tb/rfs_bridge_model.sv
`timescale 1ns/100ps
module rfs_bridge_model (
   input  wire logic [11:0] fb_mv,              // feedback, mV
   input  wire logic [7:0]  tj_c,               // junction, C
   input  wire logic [11:0] i_ma,               // switch current, mA
   input  wire logic [9:0]  al_mv,              // alarm pin, mV
   input  wire logic        power_good_out_o,   // pg drive value
   input  wire logic        power_good_out_oe,  // pg pull enable
   output logic             ov_trip,            // above 1 V
   output logic             ov_release,         // below 0.85 V
   output logic             therm_trip,         // at 155 C
   output logic             therm_cool,         // at 135 C
   output logic             first_overcurrent,  // level one
   output logic             second_overcurrent, // 1.3 x level one
   output logic             al_pin_zero,        // pin grounded
   output logic             al_pin_high,        // above 0.2 V
   output logic             power_good_out_i    // wire level
);
   // ****
   // ideal comparators: no noise, so no chatter at thresholds
   // ****
   always_comb begin
      ov_trip            = fb_mv > 12'h3E8;
      ov_release         = fb_mv < 12'h352;
      therm_trip         = tj_c >= 8'h9B;
      therm_cool         = tj_c <= 8'h87;
      first_overcurrent  = i_ma >= 12'h3E8;
      second_overcurrent = i_ma >= 12'h514;
      al_pin_zero        = al_mv == 10'h0;
      al_pin_high        = al_mv > 10'hC8;
      // open drain with pull-up: released reads high
      power_good_out_i = power_good_out_oe ? power_good_out_o : 1'b1;
   end
endmodule

// >>> tb/testbench.sv
`timescale 1ns/100ps
`include "rfs_defs.svh"
module testbench;
   localparam logic [31:0] PER = 32'h4; // short period keeps run brief
   logic        aclk, aresetn, enable_in, irq;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        ov_trip, ov_release, therm_trip, therm_cool;
   logic        first_overcurrent, second_overcurrent;
   logic        al_pin_zero, al_pin_high;
   logic        power_good_out_i, power_good_out_o, power_good_out_oe;
   logic        bridge_switch_en, bridge_hiz, hs_turn_off;
   logic        ss_discharge, al_cap_discharge, al_cap_charge;
   logic [11:0] fb_mv, i_ma;    // analog stand-ins
   logic [7:0]  tj_c;           // junction temperature
   logic [9:0]  al_mv;          // alarm pin voltage
   logic [33:0] exp_q[$];       // noted {resp, data}
   logic [31:0] lfsr;           // random source
   int          errors, cmp_count, per, n, k;
   rfs_supervisor #(.AL_PERIOD_CYC(PER)) DUT (.*);
   rfs_bridge_model u_far (.*);
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // ****
   // helpers
   // ****
   function automatic logic [31:0] nx(input logic [31:0] v);
      nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic close_out;
      $display("compares %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [33:0] s, e);
      cmp_count++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic cb(input string nm, input logic s, e);
      check(nm, {33'h0, s}, {33'h0, e});
   endtask
   task automatic tmo(input int i);
      if (i >= 3000) begin
         errors++;
         close_out();
      end
   endtask
   // master holds each channel until its own ready edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, logic [1:0] r);
      exp_q.push_back({r, 32'h0});
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (int i = 0; i <= 3000; i++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
         tmo(i);
      end
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      exp_q.push_back(e);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (int i = 0; i <= 3000; i++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
         tmo(i);
      end
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rs(input logic [31:0] e);
      rd(`RFS_REG_STATUS, {`RFS_RESP_OKAY, e});
   endtask
   task automatic wait_sw(output int c);
      for (c = 0; bridge_switch_en !== 1'b1; c++) begin
         @(posedge aclk);
         tmo(c);
      end
   endtask
   task automatic oc2;
      i_ma <= 12'h514;
      @(posedge aclk);
      i_ma <= 12'h0;
      @(posedge aclk);
   endtask
   task automatic en_cycle;
      enable_in <= 1'b0;
      repeat (3) @(posedge aclk);
      cb("hiz", bridge_hiz, 1'b1);
      enable_in <= 1'b1;
      wait_sw(n);
      cb("restart", n < 8, 1'b1);
      wr(`RFS_REG_IRQ_STAT, 32'h1F, `RFS_RESP_OKAY);
   endtask
   // ****
   // result watcher: oldest note against each answer
   // ****
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready)
         check("rdata", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
      if (s_axi_bvalid && s_axi_bready)
         check("bresp", {s_axi_bresp, 32'h0}, exp_q.pop_front());
   end
   // ****
   // main sequence
   // ****
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, i_ma} = 14'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      enable_in = 1'b1;
      fb_mv = 12'h320;
      tj_c = 8'h19;
      al_mv = 10'h64;
      lfsr = 32'h55B0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      rd(`RFS_REG_PERIOD, {2'h0, PER});
      rs(32'h1002);
      lfsr = nx(lfsr);
      per = 4 + lfsr[1:0];
      wr(`RFS_REG_PERIOD, per, `RFS_RESP_OKAY);
      rd(`RFS_REG_PERIOD, {2'h0, 32'(per)});
      wr(`RFS_REG_IRQ_MASK, 32'h1F, `RFS_RESP_OKAY);
      rd(`RFS_REG_IRQ_MASK, {2'h0, 32'h1F});
      rd(8'h10, {`RFS_RESP_SLVERR, 32'h0});
      wr(8'h14, 32'h1, `RFS_RESP_SLVERR);
      // overvoltage, then a level inside the hysteresis band
      fb_mv <= 12'h44C;
      repeat (2) @(posedge aclk);
      cb("pg_ov", power_good_out_i, 1'b0);
      fb_mv <= 12'h384;
      repeat (4) @(posedge aclk);
      cb("hiz_band", bridge_hiz, 1'b1);
      rs(32'h0022);
      fb_mv <= 12'h320;
      repeat (3) @(posedge aclk);
      cb("sw_back", bridge_switch_en, 1'b1);
      cb("irq_ov", irq, 1'b1);
      rd(`RFS_REG_IRQ_STAT, {2'h0, 32'h1});
      wr(`RFS_REG_IRQ_STAT, 32'h1, `RFS_RESP_OKAY);
      cb("irq_clr", irq, 1'b0);
      // random currents below the second limit
      repeat (40) begin
         lfsr = nx(lfsr);
         i_ma <= {2'h0, lfsr[9:0]} + 12'h0C8;
         @(posedge aclk);
      end
      i_ma <= 12'h3E8;
      repeat (2) @(posedge aclk);
      cb("oc1_cut", hs_turn_off, 1'b1);
      cb("pg_oc1", power_good_out_i, 1'b1);
      i_ma <= 12'h0;
      @(posedge aclk);
      cb("sw_oc1", bridge_switch_en, 1'b1);
      rs(32'h1002);
      // second overcurrent, cooling, quiet watching
      oc2();
      rs(32'h0084);
      cb("ss_cool", ss_discharge, 1'b1);
      cb("al_chg", al_cap_charge, 1'b1);
      wait_sw(n);
      cb("cool_len", n >= 16 * per - 2 && n <= 16 * per + 6, 1'b1);
      rs(32'h1088);
      repeat (48 * per - 8) @(posedge aclk);
      rs(32'h1088);
      repeat (12) @(posedge aclk);
      rs(32'h1002);
      rd(`RFS_REG_IRQ_STAT, {2'h0, 32'h14});
      wr(`RFS_REG_IRQ_STAT, 32'h1F, `RFS_RESP_OKAY);
      // thermal trip held past sixteen periods
      tj_c <= 8'hA0;
      repeat (4) @(posedge aclk);
      cb("pg_th", power_good_out_i, 1'b0);
      rs(32'h00C4);
      tj_c <= 8'h8C;
      repeat (16 * per + 20) @(posedge aclk);
      cb("hiz_ext", bridge_hiz, 1'b1);
      tj_c <= 8'h82;
      wait_sw(n);
      cb("ext_len", n >= 16 * per - 2 && n <= 16 * per + 6, 1'b1);
      cb("pg_rel", power_good_out_i, 1'b1);
      repeat (48 * per + 16) @(posedge aclk);
      // sixteen alarms in a row, all but the first inside watching
      for (k = 1; k <= 16; k++) begin
         oc2();
         if (k < 16) wait_sw(n);
      end
      rs(32'h0810);
      repeat (16 * per + 60) @(posedge aclk);
      cb("latched", bridge_switch_en, 1'b0);
      en_cycle();
      rs(32'h1002);
      // forced latch, then forced hiccup
      al_mv <= 10'h12C;
      @(posedge aclk);
      oc2();
      repeat (16 * per + 40) @(posedge aclk);
      cb("f_latch", bridge_switch_en, 1'b0);
      rd(`RFS_REG_IRQ_STAT, {2'h0, 32'h0C});
      en_cycle();
      al_mv <= 10'h0;
      for (k = 0; k < 17; k++) begin
         oc2();
         wait_sw(n);
      end
      rs(32'h1088);
      close_out();
   end
endmodule
bind rfs_supervisor rfs_supervisor_sva u_sva (.*);
